// File: dv/ocfr_core_tb.sv
// Self-checking bench for the overcurrent fault response core
`timescale 1ns/1ps
module ocfr_core_tb;
  import ocfr_pkg::*;
  logic             clk;
  logic             rstn;
  logic             reg_wr, reg_rd, reg_rvalid, clear_faults, alert_n;
  logic [7:0]       reg_code, reg_wdata, reg_rdata;
  logic [0:0]       reg_page;
  logic [1:0]       run, op_on, oc, other, mask, out_enable, limiting, sb, sw, si;
  logic [1:0][15:0] interval;
  logic [7:0]       exp_q[$];
  logic [31:0]      seed;
  int               err_total = 0;
  int               checked = 0;
  int               cycles = 0;

  ocfr_host_model host (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_code(reg_code),
    .reg_page(reg_page), .reg_wdata(reg_wdata));

  // Short ticks keep the 16 ms and 1 ms units to a few cycles
  ocfr_core #(.NCH(2), .PAGE_W(1), .DELAY_TICK(4), .RETRY_TICK(2)) u_dut (
    .clk(clk), .rstn(rstn), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_code(reg_code),
    .reg_page(reg_page), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .clear_faults(clear_faults), .channel_run_pin(run), .operation_on(op_on), .oc_detect(oc),
    .other_fault_off(other), .alert_mask(mask), .restart_interval_setting(interval),
    .out_enable(out_enable), .current_limiting(limiting), .status_byte_iout_oc(sb),
    .status_word_iout(sw), .status_iout_oc_fault(si), .alert_n(alert_n));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic test_done;
    $display("Counts: checked %0d err_total %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("BAD %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic st(input int ch, input logic e);
    chk("status_byte_iout_oc", e, sb[ch]);
    chk("status_word_iout", e, sw[ch]);
    chk("status_iout_oc_fault", e, si[ch]);
  endtask

  task automatic wr(input logic [0:0] p, input logic [7:0] d);
    host.access(1'b1, OC_ACTION_CODE, p, d);
  endtask

  task automatic rd(input logic [0:0] p, input logic [7:0] e);
    exp_q.push_back(e);
    host.access(1'b0, OC_ACTION_CODE, p, 8'h00);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  // Bounded wait on an enable change; also flags a change that came too soon
  task automatic wait_en(input int ch, input logic v, input int lo, input int hi);
    int n;
    n = 0;
    while (out_enable[ch] !== v && n < hi) begin
      @(negedge clk);
      n++;
    end
    chk("out_enable", v, out_enable[ch]);
    chk("enable_delay_ok", 1'b1, n >= lo);
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      err_total++;
      test_done;
    end
  end

  // Read answers are matched against the oldest noted expectation
  always @(posedge clk) begin
    if (reg_rvalid === 1'b1) begin
      if (exp_q.size() == 0) chk("unexpected reg_rvalid", 8'h00, 8'h01);
      else chk("reg_rdata", exp_q.pop_front(), reg_rdata);
    end
  end

  initial begin
    rstn = 1'b0;
    clear_faults = 1'b0;
    {run, op_on, oc, other, mask} = '0;
    interval = {16'h0001, 16'h0003};
    seed = 32'hb3c82a30;
    cyc(12);
    rstn = 1'b1;
    chk("alert_n", 1'b1, alert_n);
    chk("out_enable", 2'b00, out_enable);
    rd(1'b0, OC_ACTION_RESET);
    rd(1'b1, OC_ACTION_RESET);
    seed = lfsr(seed);
    wr(1'b1, seed[7:0]);
    rd(1'b1, seed[7:0]);
    host.access(1'b0, 8'h46, 1'b0, 8'h00);
    host.access(1'b1, 8'h48, 1'b1, 8'h55);
    rd(1'b1, seed[7:0]);
    $display("Register test done");
    // Retry code 110 is the top end of the latch-off range
    wr(1'b1, 8'hf0);
    wr(1'b0, 8'hf0);
    rd(1'b0, 8'hf0);
    mask = 2'b10;
    run = 2'b11;
    op_on = 2'b11;
    cyc(3);
    chk("out_enable", 2'b11, out_enable);
    oc = 2'b10;
    cyc(2);
    oc = 2'b00;
    st(1, 1'b1);
    chk("alert_n", 1'b1, alert_n);
    chk("out_enable", 2'b01, out_enable);
    oc = 2'b01;
    cyc(2);
    oc = 2'b00;
    chk("alert_n", 1'b0, alert_n);
    chk("out_enable", 2'b00, out_enable);
    cyc(10);
    st(0, 1'b1);
    clear_faults = 1'b1;
    cyc(1);
    clear_faults = 1'b0;
    cyc(2);
    st(0, 1'b0);
    chk("alert_n", 1'b1, alert_n);
    oc = 2'b01;
    cyc(3);
    oc = 2'b00;
    st(0, 1'b0);
    chk("out_enable", 2'b00, out_enable);
    run = 2'b00;
    cyc(2);
    run = 2'b11;
    cyc(3);
    chk("out_enable", 2'b11, out_enable);
    $display("Immediate shutdown test done");
    wr(1'b0, 8'h07);
    oc = 2'b01;
    cyc(20);
    chk("out_enable", 1'b1, out_enable[0]);
    chk("current_limiting", 1'b1, limiting[0]);
    st(0, 1'b1);
    // The unsupported code must not shut the channel down
    wr(1'b0, 8'h47);
    cyc(5);
    chk("out_enable", 1'b1, out_enable[0]);
    chk("current_limiting", 1'b1, limiting[0]);
    wr(1'b0, 8'h82);
    wait_en(0, 1'b0, 8, 16);
    oc = 2'b00;
    cyc(10);
    chk("out_enable", 1'b0, out_enable[0]);
    $display("Limit tests done");
    run[0] = 1'b0;
    cyc(2);
    run[0] = 1'b1;
    wr(1'b0, 8'hf8);
    oc = 2'b01;
    cyc(2);
    oc = 2'b00;
    chk("out_enable", 1'b0, out_enable[0]);
    // Lower bound is interval 3 times the shortened 2-cycle unit
    wait_en(0, 1'b1, 6, 14);
    oc = 2'b01;
    cyc(2);
    oc = 2'b00;
    other = 2'b01;
    cyc(20);
    chk("out_enable", 1'b0, out_enable[0]);
    other = 2'b00;
    $display("Retry tests done");
    st(0, 1'b1);
    rstn = 1'b0;
    cyc(2);
    rstn = 1'b1;
    st(0, 1'b0);
    chk("alert_n", 1'b1, alert_n);
    chk("out_enable", 2'b00, out_enable);
    rd(1'b0, OC_ACTION_RESET);
    cyc(2);
    chk("pending reads", 8'h00, 8'(exp_q.size()));
    $display("Reset test done");
    test_done;
  end
endmodule

// File: dv/ocfr_host_model.sv
// Host model driving the action byte register port
`timescale 1ns/1ps
module ocfr_host_model (
  input  wire logic       clk,
  output logic            reg_wr,
  output logic            reg_rd,
  output logic [7:0]      reg_code,
  output logic [0:0]      reg_page,
  output logic [7:0]      reg_wdata
);
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_code = 8'h00;
    reg_page = 1'b0;
    reg_wdata = 8'h00;
  end

  // One-cycle strobe; released lines show the inverse so stale values never look valid
  task automatic access(input logic wr, input logic [7:0] code, input logic [0:0] page, input logic [7:0] data);
    @(negedge clk);
    reg_wr = wr;
    reg_rd = ~wr;
    reg_code = code;
    reg_page = page;
    reg_wdata = data;
    @(negedge clk);
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_code = ~code;
    reg_page = ~page;
    reg_wdata = ~data;
  endtask
endmodule

// File: src/ocfr_core.sv
// Per-channel output overcurrent fault response with action register and alert
//
// Notes on behaviour
// - Overcurrent fault sets status byte, status word and overcurrent status bits.
// - Fault drives alert low unless that channel is masked from alerting.
// - Fault bit holds until clear command, off-then-on cycle, or reset.
// - Response 00 keeps running with constant-current limiting; 01 unsupported.
// - Response 10 limits for the delay, then applies retry if still limiting.
// - Response 11 disables the output at once, then applies retry.
// - Retry 000 to 110 latches off until run cycled or reset.
// - Retry 111 restarts without limit until commanded off or other fault.
// - Restart attempts are spaced by the separate restart interval setting.
// - Delay field counts 16 ms units of operation before shutdown.
// - Delay field matters only under the delayed shutdown response.
// - Action byte is host read/write, kept per page, defaults to 0x00.
`timescale 1ns/1ps
module ocfr_core
  import ocfr_pkg::*;
#(
  parameter int NCH          = 2,
  parameter int PAGE_W       = 1,
  parameter int DELAY_TICK   = ocfr_pkg::DELAY_TICK_DFLT,
  parameter int RETRY_TICK   = ocfr_pkg::RETRY_TICK_DFLT
) (
  input  wire logic                                  clk,
  input  wire logic                                  rstn,
  input  wire logic                                  reg_wr,
  input  wire logic                                  reg_rd,
  input  wire logic [7:0]                            reg_code,
  input  wire logic [PAGE_W-1:0]                     reg_page,
  input  wire logic [7:0]                            reg_wdata,
  output logic [7:0]                                 reg_rdata,
  output logic                                       reg_rvalid,
  input  wire logic                                  clear_faults,
  input  wire logic [NCH-1:0]                        channel_run_pin,
  input  wire logic [NCH-1:0]                        operation_on,
  input  wire logic [NCH-1:0]                        oc_detect,
  input  wire logic [NCH-1:0]                        other_fault_off,
  input  wire logic [NCH-1:0]                        alert_mask,
  input  wire logic [NCH-1:0][ocfr_pkg::INTERVAL_W-1:0] restart_interval_setting,
  output logic [NCH-1:0]                             out_enable,
  output logic [NCH-1:0]                             current_limiting,
  output logic [NCH-1:0]                             status_byte_iout_oc,
  output logic [NCH-1:0]                             status_word_iout,
  output logic [NCH-1:0]                             status_iout_oc_fault,
  output logic                                       alert_n
);

  // One flop set for all channels; the three status outputs share the sticky fault flop
  typedef struct packed {
    ocfr_state_t [NCH-1:0] st;
    logic [NCH-1:0][7:0]   action;
    logic [NCH-1:0]        fault;
    logic [NCH-1:0]        on_prev;
    logic [NCH-1:0]        out_en;
    logic [NCH-1:0]        limiting;
    logic                  alert_n;
    logic [7:0]            rdata;
    logic                  rvalid;
  } ocfr_core_t;

  ocfr_core_t core_reg;
  ocfr_core_t core_next;

  logic [NCH-1:0] delay_tick;
  logic [NCH-1:0] delay_done;
  logic [NCH-1:0] retry_tick;
  logic [NCH-1:0] retry_done;
  logic [NCH-1:0] delay_run;
  logic [NCH-1:0] retry_run;
  logic [NCH-1:0] on_w;

  // Where a shutdown goes: endless restart or latch-off
  function automatic ocfr_state_t shut_next(input logic [7:0] act);
    if (act[RETRY_HI:RETRY_LO] == RETRY_FOREVER) begin
      shut_next = ST_RETRY;
    end else begin
      shut_next = ST_LATCHED;
    end
  endfunction

  assign on_w = channel_run_pin & operation_on;

  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_ch
      assign delay_run[g] = (core_reg.st[g] == ST_LIMIT);
      assign retry_run[g] = (core_reg.st[g] == ST_RETRY);

      ocfr_prescaler #(.TICK_CYCLES(DELAY_TICK)) u_delay_pre (
        .clk  (clk),
        .rstn (rstn),
        .run  (delay_run[g]),
        .tick (delay_tick[g])
      );
      ocfr_tick_count #(.W(DELAY_W)) u_delay_cnt (
        .clk   (clk),
        .rstn  (rstn),
        .run   (delay_run[g]),
        .tick  (delay_tick[g]),
        .limit (core_reg.action[g][DELAY_HI:DELAY_LO]),
        .done  (delay_done[g])
      );
      ocfr_prescaler #(.TICK_CYCLES(RETRY_TICK)) u_retry_pre (
        .clk  (clk),
        .rstn (rstn),
        .run  (retry_run[g]),
        .tick (retry_tick[g])
      );
      ocfr_tick_count #(.W(INTERVAL_W)) u_retry_cnt (
        .clk   (clk),
        .rstn  (rstn),
        .run   (retry_run[g]),
        .tick  (retry_tick[g]),
        .limit (restart_interval_setting[g]),
        .done  (retry_done[g])
      );
    end
  endgenerate

  always_comb begin
    logic [1:0] resp;
    logic       on;
    resp      = RESP_CONST_LIMIT;
    on        = 1'b0;
    core_next = core_reg;
    core_next.rvalid = 1'b0;
    for (int c = 0; c < NCH; c++) begin
      on   = on_w[c];
      resp = core_reg.action[c][RESP_HI:RESP_LO];
      core_next.on_prev[c] = on;
      if (reg_wr && reg_code == OC_ACTION_CODE && reg_page == PAGE_W'(c)) begin
        core_next.action[c] = reg_wdata;
      end
      // Clear first so that a fault in the same cycle still lands
      if (clear_faults || (on && !core_reg.on_prev[c])) begin
        core_next.fault[c] = 1'b0;
      end
      if (oc_detect[c] && core_reg.out_en[c]) begin
        core_next.fault[c] = 1'b1;
      end
      case (core_reg.st[c])
        ST_OFF: begin
          if (on) begin
            core_next.st[c] = ST_RUN;
          end
        end
        ST_RUN: begin
          if (oc_detect[c]) begin
            if (resp == RESP_DELAYED_OFF) begin
              core_next.st[c] = ST_LIMIT;
            end else if (resp == RESP_IMMEDIATE_OFF) begin
              core_next.st[c] = shut_next(core_reg.action[c]);
            end
            // Constant limiting and the unsupported code keep running
          end
        end
        ST_LIMIT: begin
          if (!oc_detect[c]) begin
            core_next.st[c] = ST_RUN;
          end else if (delay_done[c]) begin
            core_next.st[c] = shut_next(core_reg.action[c]);
          end
        end
        ST_LATCHED: begin
          core_next.st[c] = ST_LATCHED;
        end
        ST_RETRY: begin
          if (other_fault_off[c]) begin
            core_next.st[c] = ST_LATCHED;
          end else if (retry_done[c]) begin
            core_next.st[c] = ST_RUN;
          end
        end
        default: begin
          core_next.st[c] = ST_OFF;
        end
      endcase
      if (!on) begin
        core_next.st[c] = ST_OFF;
      end
      core_next.out_en[c] = (core_next.st[c] == ST_RUN) || (core_next.st[c] == ST_LIMIT);
      core_next.limiting[c] = core_next.out_en[c] && oc_detect[c] && (resp != RESP_IMMEDIATE_OFF);
    end
    core_next.alert_n = ~|(core_next.fault & ~alert_mask);
    if (reg_rd && reg_code == OC_ACTION_CODE) begin
      core_next.rdata  = core_reg.action[reg_page];
      core_next.rvalid = 1'b1;
    end
  end

  // Nothing nonvolatile is kept, so action bytes return to their default here
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      core_reg         <= '0;
      core_reg.st      <= '{default: ST_OFF};
      core_reg.action  <= {NCH{OC_ACTION_RESET}};
      core_reg.alert_n <= 1'b1;
    end else begin
      core_reg <= core_next;
    end
  end

  assign reg_rdata            = core_reg.rdata;
  assign reg_rvalid           = core_reg.rvalid;
  assign out_enable           = core_reg.out_en;
  assign current_limiting     = core_reg.limiting;
  assign status_byte_iout_oc  = core_reg.fault;
  assign status_word_iout     = core_reg.fault;
  assign status_iout_oc_fault = core_reg.fault;
  assign alert_n              = core_reg.alert_n;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  // Read answers come only from a valid request; alert rests high with no fault held
  a_read_refused: assert property (!(reg_rd && reg_code == OC_ACTION_CODE) |=> !reg_rvalid)
    else $error("read answered without a valid request");
  a_alert_quiet: assert property (!(|core_reg.fault) |-> alert_n)
    else $error("alert raised with no fault held");

  generate
    for (g = 0; g < NCH; g++) begin : g_chk
      sequence s_run_oc(logic [1:0] r);
        core_reg.st[g] == ST_RUN && oc_detect[g] && on_w[g] && core_reg.action[g][RESP_HI:RESP_LO] == r;
      endsequence
      sequence s_limit_expire;
        core_reg.st[g] == ST_LIMIT && oc_detect[g] && on_w[g] && !delay_done[g];
      endsequence
      sequence s_limit_release;
        core_reg.st[g] == ST_LIMIT && !oc_detect[g] && on_w[g];
      endsequence
      sequence s_timer_cleared;
        core_reg.st[g] == ST_RUN ##1 !delay_done[g];
      endsequence

      a_fault_sets_status: assert property (oc_detect[g] && core_reg.out_en[g] |=>
        status_iout_oc_fault[g] && status_word_iout[g] && status_byte_iout_oc[g])
        else $error("overcurrent did not set status");
      a_alert_on_fault: assert property ($rose(core_reg.fault[g]) && !$past(alert_mask[g]) |-> !alert_n)
        else $error("alert not raised on fault");
      a_fault_holds: assert property (core_reg.fault[g] && !clear_faults &&
        !(on_w[g] && !core_reg.on_prev[g]) |=> core_reg.fault[g])
        else $error("fault bit dropped without clear");
      a_const_limit_runs: assert property (s_run_oc(RESP_CONST_LIMIT) |=> out_enable[g] && current_limiting[g])
        else $error("constant limit response left run");
      a_delay_entry: assert property (s_run_oc(RESP_DELAYED_OFF) |=> core_reg.st[g] == ST_LIMIT)
        else $error("delayed response did not limit");
      a_immediate_off: assert property (s_run_oc(RESP_IMMEDIATE_OFF) |=> !out_enable[g])
        else $error("immediate response kept output on");
      a_latch_holds: assert property (core_reg.st[g] == ST_LATCHED && on_w[g] |=> !out_enable[g])
        else $error("latched channel restarted");
      a_retry_stops: assert property (core_reg.st[g] == ST_RETRY && !on_w[g] |=> core_reg.st[g] == ST_OFF)
        else $error("retry continued after off command");
      a_retry_spacing: assert property (core_reg.st[g] == ST_RETRY && !retry_done[g] && on_w[g] &&
        !other_fault_off[g] |=> core_reg.st[g] == ST_RETRY)
        else $error("restart before interval elapsed");
      a_delay_holds: assert property (s_limit_expire |=> out_enable[g])
        else $error("shutdown before delay expired");
      a_delay_ignored: assert property (s_run_oc(RESP_IMMEDIATE_OFF) |=> core_reg.st[g] != ST_LIMIT)
        else $error("delay used outside delayed response");
      a_action_write: assert property (reg_wr && reg_code == OC_ACTION_CODE && reg_page == PAGE_W'(g)
        |=> core_reg.action[g] == $past(reg_wdata))
        else $error("action byte not written");
      // A read of this channel's page must answer on the next cycle with the action byte it held
      a_read_answer: assert property (reg_rd && reg_code == OC_ACTION_CODE && reg_page == PAGE_W'(g)
        |=> reg_rvalid && reg_rdata == $past(core_reg.action[g]))
        else $error("read answer wrong or late");
      a_clear_drops: assert property (clear_faults && !(oc_detect[g] && core_reg.out_en[g])
        |=> !status_iout_oc_fault[g])
        else $error("clear command left fault set");
      a_cycle_drops: assert property (on_w[g] && !core_reg.on_prev[g] &&
        !(oc_detect[g] && core_reg.out_en[g]) |=> !core_reg.fault[g])
        else $error("off then on left fault set");
      a_no_fault_off: assert property (!core_reg.out_en[g] && !core_reg.fault[g] |=> !core_reg.fault[g])
        else $error("fault set while output disabled");
      a_alert_level: assert property (core_reg.fault[g] && !$past(alert_mask[g]) |-> !alert_n)
        else $error("unmasked fault without alert");
      a_limit_flag: assert property (current_limiting[g] |-> out_enable[g])
        else $error("limiting flagged with output off");
      a_const_no_delay: assert property (s_run_oc(RESP_CONST_LIMIT) |=> core_reg.st[g] != ST_LIMIT)
        else $error("delay used under constant limiting");
      a_delay_expiry: assert property (core_reg.st[g] == ST_LIMIT && oc_detect[g] && on_w[g] &&
        delay_done[g] |=> !out_enable[g])
        else $error("output kept on after delay expired");
      a_timer_restart: assert property (s_limit_release |=> s_timer_cleared)
        else $error("delay timer kept count after fault cleared");
      a_retry_latch: assert property (core_reg.st[g] == ST_RETRY && other_fault_off[g] && on_w[g]
        |=> core_reg.st[g] == ST_LATCHED)
        else $error("retry went on after another fault");
      a_retry_restart: assert property (core_reg.st[g] == ST_RETRY && retry_done[g] && on_w[g] &&
        !other_fault_off[g] |=> out_enable[g])
        else $error("no restart after interval");
      a_off_disables: assert property (!on_w[g] |=> !out_enable[g])
        else $error("output on while commanded off");
      a_latch_release: assert property (core_reg.st[g] == ST_LATCHED && !on_w[g]
        |=> core_reg.st[g] == ST_OFF)
        else $error("latched channel ignored off command");
    end
  endgenerate
endmodule

// File: src/ocfr_pkg.sv
// Constants, field layout and states of the overcurrent fault response block
package ocfr_pkg;
  localparam int          CLK_HZ             = 100_000_000;
  localparam int          MS_PER_S           = 1000;
  localparam int          DELAY_UNIT_MS      = 16;
  localparam int          RETRY_UNIT_MS      = 1;
  localparam int          DELAY_TICK_DFLT    = CLK_HZ / MS_PER_S * DELAY_UNIT_MS;
  localparam int          RETRY_TICK_DFLT    = CLK_HZ / MS_PER_S * RETRY_UNIT_MS;
  localparam logic [7:0]  OC_ACTION_CODE     = 8'h47;
  localparam logic [7:0]  OC_ACTION_RESET    = 8'h00;
  localparam int          RESP_HI            = 7;
  localparam int          RESP_LO            = 6;
  localparam int          RETRY_HI           = 5;
  localparam int          RETRY_LO           = 3;
  localparam int          DELAY_HI           = 2;
  localparam int          DELAY_LO           = 0;
  localparam int          DELAY_W            = DELAY_HI - DELAY_LO + 1;
  localparam int          RETRY_W            = RETRY_HI - RETRY_LO + 1;
  localparam int          INTERVAL_W         = 16;
  localparam logic [1:0]  RESP_CONST_LIMIT   = 2'h0;
  localparam logic [1:0]  RESP_UNSUPPORTED   = 2'h1;
  localparam logic [1:0]  RESP_DELAYED_OFF   = 2'h2;
  localparam logic [1:0]  RESP_IMMEDIATE_OFF = 2'h3;
  localparam logic [2:0]  RETRY_FOREVER      = 3'h7;

  typedef enum logic [4:0] {
    ST_OFF     = 5'h01,
    ST_RUN     = 5'h02,
    ST_LIMIT   = 5'h04,
    ST_LATCHED = 5'h08,
    ST_RETRY   = 5'h10
  } ocfr_state_t;
endpackage

// File: src/ocfr_prescaler.sv
// Tick prescaler: one-cycle tick every TICK_CYCLES clocks while run is high
`timescale 1ns/1ps
module ocfr_prescaler #(
  parameter int TICK_CYCLES = 100
) (
  input  wire logic clk,
  input  wire logic rstn,
  input  wire logic run,
  output logic      tick
);
  import ocfr_pkg::*;
  localparam int CW = $clog2(TICK_CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(TICK_CYCLES - 1);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic          tick;
  } ocfr_pre_t;

  ocfr_pre_t pre_reg;
  ocfr_pre_t pre_next;

  always_comb begin
    pre_next      = pre_reg;
    pre_next.tick = 1'b0;
    if (!run) begin
      pre_next.cnt = '0;
    end else if (pre_reg.cnt == LAST) begin
      pre_next.cnt  = '0;
      pre_next.tick = 1'b1;
    end else begin
      pre_next.cnt = pre_reg.cnt + CW'(1);
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pre_reg <= '0;
    end else begin
      pre_reg <= pre_next;
    end
  end

  assign tick = pre_reg.tick;
endmodule

// File: src/ocfr_tick_count.sv
// Tick counter: done rises once limit ticks have passed while run stays high
`timescale 1ns/1ps
module ocfr_tick_count #(
  parameter int W = 8
) (
  input  wire logic         clk,
  input  wire logic         rstn,
  input  wire logic         run,
  input  wire logic         tick,
  input  wire logic [W-1:0] limit,
  output logic              done
);
  import ocfr_pkg::*;

  typedef struct packed {
    logic [W-1:0] cnt;
    logic         done;
  } ocfr_cnt_t;

  ocfr_cnt_t cnt_reg;
  ocfr_cnt_t cnt_next;

  // Restarts from zero whenever run drops, so a cleared fault starts afresh
  always_comb begin
    cnt_next = cnt_reg;
    if (!run) begin
      cnt_next = '0;
    end else if (cnt_reg.cnt >= limit) begin
      cnt_next.done = 1'b1;
    end else if (tick) begin
      cnt_next.cnt = cnt_reg.cnt + W'(1);
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  assign done = cnt_reg.done;
endmodule
